/* tac_consts.svh */
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH
// Register byte offsets on the APB slave.
`define TAC_OFS_TIME_CONST 12'h000
`define TAC_OFS_EXT_TRIP 12'h004
`define TAC_OFS_RESET_REQ 12'h008
`define TAC_OFS_ATTEMPTS 12'h00c
`define TAC_OFS_DELAY 12'h010
`define TAC_OFS_HOLD_HEALTHY 12'h014
`define TAC_OFS_ACTIONS 12'h018
`define TAC_OFS_RATED_POWER 12'h01c
`define TAC_OFS_UV_HOLD 12'h020
`define TAC_OFS_STATUS 12'h024
`define TAC_OFS_ACCUM 12'h028
`define TAC_OFS_COUNT 12'h02c
// Accumulator scale: full scale is 100 %, release at 95.0 %.
`define TAC_ACC_FULL 16'h2710
`define TAC_ACC_LOW 16'h251c
// Attempt setting values.
`define TAC_ATT_OFF 3'h0
`define TAC_ATT_INF 3'h6
// Action bits.
`define TAC_ACT_STOP 0
`define TAC_ACT_BRAKE 1
`define TAC_ACT_PHASE 2
// Delays in tenths of a second; clock ticks per tenth at 100 MHz.
`define TAC_DELAY_RST 32'h0000000a
`define TAC_DELAY_MIN 32'h0000000a
`define TAC_DELAY_MAX 32'h00001770
`define TAC_LONG_MIN 32'h00000064
`define TAC_IDLE_TENTHS 32'h00000bb8
`define TAC_TICK_NS 100000000
`define TAC_CLK_NS 10
`define TAC_EXT_CODE 8'h03
`define TAC_PRIO_NORESET 3'h3
`endif

/* tac_pkg.sv */
package tac_pkg;
	typedef enum logic [1:0] {
		TAC_IDLE = 2'b00,
		TAC_WAIT = 2'b01,
		TAC_LOCK = 2'b11
	} tac_state_t;
endpackage

/* tac_trip_ctrl.sv */
`timescale 1ns/1ns
`include "tac_consts.svh"
// Operation
// - With bit 1 clear, accumulator at full scale raises resistor overheat trip.
// - With bit 1 set, full accumulator disables brake switch until below 95 %.
// - External trip bit high starts external trip with sub-code three.
// - Each rising edge of reset request bit performs drive reset.
// - Attempts 0 disables, 1 to 5 limit, 6 unlimited.
// - Auto reset waits programmed delay, never below trip minimum reset time.
// - Same trip increments count; a different trip clears it.
// - Count at limit blocks automatic reset of further trips with the same code.
// - Five minutes without trip below limit clears the count.
// - Priority 1, 2 or 3 trips are never auto reset.
// - Manual reset clears the auto-reset count.
// - Attempts equal six holds the count at zero.
// - Hold option clear: healthy cleared on every trip.
// - Hold option set: healthy kept while more attempts remain.
// - Undervoltage entry clears healthy unless its hold option is one.
// - Five-bit action field, default zero, bit 1 brake, bit 3 unused.
// - Bit 0 stops before listed soft trips, not in regen mode.
// - Bit 2 keeps running on phase loss until stopped, not in regen.
// - Zero rated power disables protection and holds accumulator zero.
// - Accumulator follows one time constant model from resistor power.
module tac_trip_ctrl
	import tac_pkg::*;
#(
	parameter int TICK_CYCLES = `TAC_TICK_NS / `TAC_CLK_NS,
	parameter logic [31:0] IDLE_TENTHS = `TAC_IDLE_TENTHS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] brake_power,
	input wire logic trip_event,
	input wire logic [7:0] trip_code,
	input wire logic [2:0] trip_priority,
	input wire logic long_reset_trip,
	input wire logic soft_trip,
	input wire logic phase_loss,
	input wire logic motor_stopped,
	input wire logic regen_mode,
	input wire logic undervoltage,
	input wire logic ext_trip_pin,
	input wire logic reset_pin,
	output logic brake_trip,
	output logic brake_enable,
	output logic ext_trip,
	output logic [7:0] ext_sub_code,
	output logic drive_reset,
	output logic auto_reset,
	output logic stop_request,
	output logic phase_trip,
	output logic healthy
);
	logic [31:0] time_const, delay, rated_power;
	logic ext_req, reset_req, hold_healthy, uv_hold;
	logic [2:0] attempts;
	logic [4:0] actions;
	logic [1:0] ext_sync, rst_sync;
	logic rst_last, uv_last, tripped;
	logic [15:0] accum;
	logic [2:0] count;
	logic [7:0] last_code;
	logic [31:0] tick_cnt, wait_tenths, idle_tenths, tc_cnt;
	tac_state_t state;
	logic [31:0] next_prdata, next_delay, next_wait, next_idle, next_tick, next_tc;
	logic next_ext_req, next_reset_req, next_hold, next_uv_hold, next_pready;
	logic [2:0] next_attempts, next_count;
	logic [4:0] next_actions;
	logic [31:0] next_time_const, next_rated;
	logic [15:0] next_accum;
	logic [7:0] next_last;
	tac_state_t next_state;
	logic next_brake_trip, next_brake_en, next_ext_trip, next_drive_reset, next_auto;
	logic next_stop, next_phase, next_healthy, next_tripped, next_pslverr;
	logic wr, rd, tick, reset_rise, manual, ext_now, rst_now, remains, is_std;
	logic [31:0] min_tenths;
	logic [2:0] eff_count;

	assign wr = psel && penable && pwrite && !pready;
	assign rd = psel && !penable;
	assign tick = tick_cnt == 32'(TICK_CYCLES - 1);
	assign ext_now = ext_req || ext_sync[1];
	assign rst_now = reset_req || rst_sync[1];
	assign reset_rise = rst_now && !rst_last;
	assign manual = reset_rise;
	assign is_std = trip_priority > `TAC_PRIO_NORESET;
	// A different trip starts from a cleared count, so it may still be reset at the limit.
	assign eff_count = trip_event && trip_code != last_code ? 3'h0 : count;
	assign remains = attempts != `TAC_ATT_OFF && is_std &&
		(attempts == `TAC_ATT_INF || eff_count < attempts);
	assign min_tenths = long_reset_trip && delay < `TAC_LONG_MIN ? `TAC_LONG_MIN : delay;

	always_comb begin
		next_time_const = time_const;
		next_ext_req = ext_req;
		next_reset_req = reset_req;
		next_attempts = attempts;
		next_delay = delay;
		next_hold = hold_healthy;
		next_actions = actions;
		next_rated = rated_power;
		next_uv_hold = uv_hold;
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		if (wr) begin
			case (paddr)
				`TAC_OFS_TIME_CONST: next_time_const = pwdata;
				`TAC_OFS_EXT_TRIP: next_ext_req = pwdata[0];
				`TAC_OFS_RESET_REQ: next_reset_req = pwdata[0];
				`TAC_OFS_ATTEMPTS: next_attempts = pwdata[2:0] > `TAC_ATT_INF ?
					`TAC_ATT_INF : pwdata[2:0];
				`TAC_OFS_DELAY: next_delay = pwdata < `TAC_DELAY_MIN ? `TAC_DELAY_MIN :
					pwdata > `TAC_DELAY_MAX ? `TAC_DELAY_MAX : pwdata;
				`TAC_OFS_HOLD_HEALTHY: next_hold = pwdata[0];
				`TAC_OFS_ACTIONS: next_actions = pwdata[4:0];
				`TAC_OFS_RATED_POWER: next_rated = pwdata;
				`TAC_OFS_UV_HOLD: next_uv_hold = pwdata[0];
				`TAC_OFS_STATUS, `TAC_OFS_ACCUM, `TAC_OFS_COUNT: ;
				default: next_pslverr = 1'b1;
			endcase
		end
		if (rd) begin
			case (paddr)
				`TAC_OFS_TIME_CONST: next_prdata = time_const;
				`TAC_OFS_EXT_TRIP: next_prdata = {31'h0, ext_req};
				`TAC_OFS_RESET_REQ: next_prdata = {31'h0, reset_req};
				`TAC_OFS_ATTEMPTS: next_prdata = {29'h0, attempts};
				`TAC_OFS_DELAY: next_prdata = delay;
				`TAC_OFS_HOLD_HEALTHY: next_prdata = {31'h0, hold_healthy};
				`TAC_OFS_ACTIONS: next_prdata = {27'h0, actions};
				`TAC_OFS_RATED_POWER: next_prdata = rated_power;
				`TAC_OFS_UV_HOLD: next_prdata = {31'h0, uv_hold};
				`TAC_OFS_STATUS: next_prdata = {25'h0, state, tripped, healthy, brake_enable,
					brake_trip, ext_trip};
				`TAC_OFS_ACCUM: next_prdata = {16'h0, accum};
				`TAC_OFS_COUNT: next_prdata = {29'h0, count};
				default: next_prdata = 32'h0;
			endcase
		end
		if (psel && penable && !pready && !pwrite && next_prdata == prdata &&
			!(paddr inside {`TAC_OFS_TIME_CONST, `TAC_OFS_EXT_TRIP, `TAC_OFS_RESET_REQ,
			`TAC_OFS_ATTEMPTS, `TAC_OFS_DELAY, `TAC_OFS_HOLD_HEALTHY, `TAC_OFS_ACTIONS,
			`TAC_OFS_RATED_POWER, `TAC_OFS_UV_HOLD, `TAC_OFS_STATUS, `TAC_OFS_ACCUM,
			`TAC_OFS_COUNT}))
			next_pslverr = 1'b1;
	end

	// Every time_const ticks the accumulator leaks accum/8 and gains brake_power, a one-pole model.
	always_comb begin
		next_accum = accum;
		next_tc = tc_cnt;
		next_brake_en = brake_enable;
		next_brake_trip = 1'b0;
		if (rated_power == 32'h0) begin
			next_accum = 16'h0;
			next_brake_en = 1'b1;
		end else if (tick) begin
			if (tc_cnt + 32'h1 >= time_const) begin
				next_tc = 32'h0;
				if (32'(accum) + 32'(brake_power) >= 32'(`TAC_ACC_FULL) + 32'(accum) / 32'h8)
					next_accum = `TAC_ACC_FULL;
				else
					next_accum = 16'(32'(accum) - 32'(accum) / 32'h8 + 32'(brake_power));
			end else begin
				next_tc = tc_cnt + 32'h1;
			end
		end
		if (rated_power != 32'h0 && accum >= `TAC_ACC_FULL) begin
			if (actions[`TAC_ACT_BRAKE])
				next_brake_en = 1'b0;
			else
				next_brake_trip = 1'b1;
		end
		if (!brake_enable && accum < `TAC_ACC_LOW)
			next_brake_en = 1'b1;
	end

	always_comb begin
		next_state = state;
		next_count = count;
		next_last = last_code;
		next_wait = wait_tenths;
		next_idle = idle_tenths;
		next_tick = tick ? 32'h0 : tick_cnt + 32'h1;
		next_auto = 1'b0;
		next_tripped = tripped;
		next_healthy = healthy;
		if (tick && idle_tenths < IDLE_TENTHS)
			next_idle = idle_tenths + 32'h1;
		if (idle_tenths >= IDLE_TENTHS && attempts != `TAC_ATT_INF && count < attempts)
			next_count = 3'h0;
		if (trip_event) begin
			next_tripped = 1'b1;
			next_idle = 32'h0;
			next_last = trip_code;
			if (trip_code != last_code)
				next_count = 3'h0;
			if (!(hold_healthy && remains))
				next_healthy = 1'b0;
			if (remains) begin
				next_state = TAC_WAIT;
				next_wait = min_tenths;
			end else begin
				next_state = TAC_LOCK;
			end
		end else if (state == TAC_WAIT) begin
			if (tick) begin
				next_wait = wait_tenths - 32'h1;
				if (wait_tenths <= 32'h1) begin
					next_auto = 1'b1;
					next_state = TAC_IDLE;
					next_tripped = 1'b0;
					next_healthy = 1'b1;
					if (attempts != `TAC_ATT_INF && count < attempts)
						next_count = count + 3'h1;
				end
			end
		end
		if (attempts == `TAC_ATT_INF)
			next_count = 3'h0;
		// A trip in the same cycle as a manual reset wins, so the new trip is never lost.
		if (manual) begin
			next_count = 3'h0;
			if (!trip_event) begin
				next_state = TAC_IDLE;
				next_tripped = 1'b0;
				next_healthy = 1'b1;
			end
		end
		if (undervoltage && !uv_last && !uv_hold)
			next_healthy = 1'b0;
		next_ext_trip = ext_now;
		next_drive_reset = reset_rise;
		next_stop = soft_trip && actions[`TAC_ACT_STOP] && !regen_mode;
		next_phase = phase_loss &&
			(!actions[`TAC_ACT_PHASE] || regen_mode || motor_stopped);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			time_const <= 32'h0;
			ext_req <= 1'b0;
			reset_req <= 1'b0;
			attempts <= `TAC_ATT_OFF;
			delay <= `TAC_DELAY_RST;
			hold_healthy <= 1'b0;
			actions <= 5'h0;
			rated_power <= 32'h0;
			uv_hold <= 1'b0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ext_sync <= 2'h0;
			rst_sync <= 2'h0;
			rst_last <= 1'b0;
			uv_last <= 1'b0;
			accum <= 16'h0;
			tc_cnt <= 32'h0;
			brake_enable <= 1'b1;
			brake_trip <= 1'b0;
			state <= TAC_IDLE;
			count <= 3'h0;
			last_code <= 8'h0;
			wait_tenths <= 32'h0;
			idle_tenths <= 32'h0;
			tick_cnt <= 32'h0;
			auto_reset <= 1'b0;
			tripped <= 1'b0;
			healthy <= 1'b1;
			ext_trip <= 1'b0;
			ext_sub_code <= 8'h0;
			drive_reset <= 1'b0;
			stop_request <= 1'b0;
			phase_trip <= 1'b0;
		end else begin
			time_const <= next_time_const;
			ext_req <= next_ext_req;
			reset_req <= next_reset_req;
			attempts <= next_attempts;
			delay <= next_delay;
			hold_healthy <= next_hold;
			actions <= next_actions;
			rated_power <= next_rated;
			uv_hold <= next_uv_hold;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr && next_pready;
			ext_sync <= {ext_sync[0], ext_trip_pin};
			rst_sync <= {rst_sync[0], reset_pin};
			rst_last <= rst_now;
			uv_last <= undervoltage;
			accum <= next_accum;
			tc_cnt <= next_tc;
			brake_enable <= next_brake_en;
			brake_trip <= next_brake_trip;
			state <= next_state;
			count <= next_count;
			last_code <= next_last;
			wait_tenths <= next_wait;
			idle_tenths <= next_idle;
			tick_cnt <= next_tick;
			auto_reset <= next_auto;
			tripped <= next_tripped;
			healthy <= next_healthy;
			ext_trip <= next_ext_trip;
			ext_sub_code <= next_ext_trip ? `TAC_EXT_CODE : 8'h0;
			drive_reset <= next_drive_reset;
			stop_request <= next_stop;
			phase_trip <= next_phase;
		end
	end

	chk_ext_trip_code: assert property (@(posedge pclk) disable iff (!presetn)
		ext_now |=> ext_trip && ext_sub_code == `TAC_EXT_CODE) else $error("ext trip");
	chk_reset_edge_only: assert property (@(posedge pclk) disable iff (!presetn)
		rst_now && rst_last |=> !drive_reset) else $error("level reset");
	chk_inf_count_zero: assert property (@(posedge pclk) disable iff (!presetn)
		attempts == `TAC_ATT_INF |=> count == 3'h0) else $error("count held");
	chk_manual_clears: assert property (@(posedge pclk) disable iff (!presetn)
		manual |=> count == 3'h0 && drive_reset) else $error("manual reset");
	chk_zero_power_accum: assert property (@(posedge pclk) disable iff (!presetn)
		rated_power == 32'h0 |=> accum == 16'h0) else $error("accum held");
	chk_brake_trip_full: assert property (@(posedge pclk) disable iff (!presetn)
		rated_power != 32'h0 && accum >= `TAC_ACC_FULL && !actions[`TAC_ACT_BRAKE]
		|=> brake_trip) else $error("no overheat trip");
	chk_brake_off_full: assert property (@(posedge pclk) disable iff (!presetn)
		rated_power != 32'h0 && accum >= `TAC_ACC_FULL && actions[`TAC_ACT_BRAKE]
		|=> !brake_enable && !brake_trip) else $error("brake not off");
	chk_no_auto_high_prio: assert property (@(posedge pclk) disable iff (!presetn)
		trip_event && !is_std && !manual |=> state == TAC_LOCK) else $error("prio");
	chk_healthy_cleared: assert property (@(posedge pclk) disable iff (!presetn)
		trip_event && !hold_healthy && !manual |=> !healthy) else $error("healthy");
	chk_stop_regen: assert property (@(posedge pclk) disable iff (!presetn)
		regen_mode |=> !stop_request) else $error("stop in regen");
	chk_limit_locks: assert property (@(posedge pclk) disable iff (!presetn)
		trip_event && trip_code == last_code && attempts != `TAC_ATT_INF &&
		count >= attempts |=> state == TAC_LOCK) else $error("limit reached");
	cov_auto_reset: cover property (@(posedge pclk) disable iff (!presetn) auto_reset);
	cov_lock: cover property (@(posedge pclk) disable iff (!presetn) state == TAC_LOCK);
	cov_brake_off: cover property (@(posedge pclk) disable iff (!presetn) !brake_enable);
	cov_ext_trip: cover property (@(posedge pclk) disable iff (!presetn) ext_trip);
endmodule

/* trip_autoreset_control_bench.sv */
`timescale 1ns/1ns
`include "tac_consts.svh"
module trip_autoreset_control_bench;
	typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e; logic er;} tac_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] brake_power = 16'h0;
	logic trip_event = 0, long_reset_trip = 0, soft_trip = 0, phase_loss = 0, motor_stopped = 0;
	logic regen_mode = 0, undervoltage = 0, ext_trip_pin = 0, reset_pin = 0;
	logic [7:0] trip_code = 8'h00, ext_sub_code;
	logic [2:0] trip_priority = 3'h0;
	logic brake_trip, brake_enable, ext_trip, drive_reset, auto_reset, stop_request;
	logic phase_trip, healthy;
	int bad_count = 0, check_count = 0, ar_n = 0, dr_n = 0, k, p;
	// Reset values; status is healthy and brake enabled only.
	tac_row_t rst_rows [7] = '{'{`TAC_OFS_EXT_TRIP, 0, 0, 0}, '{`TAC_OFS_RESET_REQ, 0, 0, 0},
		'{`TAC_OFS_ATTEMPTS, 0, 0, 0}, '{`TAC_OFS_HOLD_HEALTHY, 0, 0, 0},
		'{`TAC_OFS_ACTIONS, 0, 0, 0}, '{`TAC_OFS_DELAY, 0, `TAC_DELAY_RST, 0},
		'{`TAC_OFS_STATUS, 0, 32'h0000000c, 0}};
	// Written value, expected read-back and error flag; delays clamp to range.
	tac_row_t rows [8] = '{'{`TAC_OFS_ATTEMPTS, 5, 5, 0}, '{`TAC_OFS_DELAY, 5, `TAC_DELAY_MIN, 0},
		'{`TAC_OFS_DELAY, 7000, `TAC_DELAY_MAX, 0}, '{`TAC_OFS_HOLD_HEALTHY, 1, 1, 0},
		'{`TAC_OFS_ACTIONS, 32'h1f, 32'h1f, 0}, '{`TAC_OFS_UV_HOLD, 1, 1, 0},
		'{`TAC_OFS_TIME_CONST, 3, 3, 0}, '{12'h100, 5, 0, 1}};

	tac_trip_ctrl #(.TICK_CYCLES(10), .IDLE_TENTHS(32'h0000003c)) dut (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .brake_power,
		.trip_event, .trip_code, .trip_priority, .long_reset_trip, .soft_trip, .phase_loss,
		.motor_stopped, .regen_mode, .undervoltage, .ext_trip_pin, .reset_pin, .brake_trip,
		.brake_enable, .ext_trip, .ext_sub_code, .drive_reset, .auto_reset, .stop_request,
		.phase_trip, .healthy);

	always #5 pclk = ~pclk;

	// Pulses are counted here so that no scenario can miss a one-cycle output.
	always @(posedge pclk) begin
		if (auto_reset === 1'b1) ar_n++;
		if (drive_reset === 1'b1) dr_n++;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer; the idle edge first keeps psel from being set twice in one step.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (t = 0; t < 20; t++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (t == 20) begin
			chk(0, 1);
			test_done();
		end
	endtask

	task automatic trip(input logic [7:0] c, input logic [2:0] pr, input int n);
		@(posedge pclk);
		trip_event <= 1;
		trip_code <= c;
		trip_priority <= pr;
		@(posedge pclk);
		trip_event <= 0;
		wt(n);
	endtask

	task automatic mreset();
		apb(1, `TAC_OFS_RESET_REQ, 1);
		apb(1, `TAC_OFS_RESET_REQ, 0);
		wt(5);
	endtask

	// Waits for brake_trip (sel 1) or brake_enable (sel 0) to reach v.
	task automatic wbr(input logic sel, input logic v);
		int t;
		for (t = 0; t < 3000; t++) begin
			@(posedge pclk);
			if ((sel ? brake_trip : brake_enable) === v) break;
		end
		chk(t < 3000, 1);
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk(healthy, 1);
		chk(brake_enable, 1);
		for (k = 0; k < 7; k++) begin
			apb(0, rst_rows[k].a, 0);
			chk(rd, rst_rows[k].e);
		end
		for (k = 0; k < 8; k++) begin
			apb(1, rows[k].a, rows[k].w);
			apb(0, rows[k].a, 0);
			chk({err, rd}, {rows[k].er, rows[k].e});
		end
		undervoltage <= 1;
		wt(4);
		chk(healthy, 1);
		undervoltage <= 0;
		apb(1, `TAC_OFS_UV_HOLD, 0);
		undervoltage <= 1;
		wt(4);
		chk(healthy, 0);
		undervoltage <= 0;
		apb(1, `TAC_OFS_ATTEMPTS, 2);
		apb(1, `TAC_OFS_DELAY, 10);
		apb(1, `TAC_OFS_HOLD_HEALTHY, 0);
		apb(1, `TAC_OFS_ACTIONS, 0);
		mreset();
		k = ar_n;
		trip(8'h05, 3'h6, 3);
		chk(healthy, 0);
		wt(80);
		chk(ar_n - k, 0);
		wt(120);
		chk(ar_n - k, 1);
		trip(8'h05, 3'h6, 200);
		trip(8'h05, 3'h6, 300);
		chk(ar_n - k, 2);
		trip(8'h06, 3'h6, 200);
		chk(ar_n - k, 3);
		k = dr_n;
		reset_pin <= 1;
		wt(8);
		chk(dr_n - k, 1);
		reset_pin <= 0;
		apb(0, `TAC_OFS_COUNT, 0);
		chk(rd, 0);
		k = ar_n;
		trip(8'h05, 3'h6, 200);
		chk(ar_n - k, 1);
		apb(0, `TAC_OFS_COUNT, 0);
		chk(rd, 1);
		wt(700);
		apb(0, `TAC_OFS_COUNT, 0);
		chk(rd, 0);
		for (p = 1; p < 4; p++) begin
			k = ar_n;
			trip(8'h09, p[2:0], 150);
			chk(ar_n - k, 0);
			mreset();
		end
		k = ar_n;
		long_reset_trip <= 1;
		trip(8'h04, 3'h6, 900);
		long_reset_trip <= 0;
		chk(ar_n - k, 0);
		wt(300);
		chk(ar_n - k, 1);
		apb(1, `TAC_OFS_ATTEMPTS, 6);
		apb(1, `TAC_OFS_HOLD_HEALTHY, 1);
		k = ar_n;
		for (p = 0; p < 3; p++) begin
			trip(8'h07, 3'h6, 3);
			chk(healthy, 1);
			wt(150);
		end
		chk(ar_n - k, 3);
		apb(0, `TAC_OFS_COUNT, 0);
		chk(rd, 0);
		apb(1, `TAC_OFS_ATTEMPTS, 0);
		k = ar_n;
		trip(8'h07, 3'h6, 200);
		chk(ar_n - k, 0);
		mreset();
		apb(1, `TAC_OFS_EXT_TRIP, 1);
		wt(3);
		chk({ext_trip, ext_sub_code}, {1'b1, `TAC_EXT_CODE});
		apb(1, `TAC_OFS_EXT_TRIP, 0);
		wt(3);
		chk(ext_trip, 0);
		ext_trip_pin <= 1;
		wt(6);
		chk(ext_trip, 1);
		ext_trip_pin <= 0;
		k = dr_n;
		apb(1, `TAC_OFS_RESET_REQ, 1);
		wt(10);
		apb(1, `TAC_OFS_RESET_REQ, 1);
		wt(10);
		chk(dr_n - k, 1);
		apb(1, `TAC_OFS_RESET_REQ, 0);
		apb(1, `TAC_OFS_RATED_POWER, 100);
		apb(1, `TAC_OFS_TIME_CONST, 1);
		apb(1, `TAC_OFS_ACTIONS, 2);
		brake_power <= 16'd2000;
		wbr(0, 0);
		chk(brake_trip, 0);
		brake_power <= 16'd0;
		wbr(0, 1);
		apb(0, `TAC_OFS_ACCUM, 0);
		chk(rd < 32'h0000251c, 1);
		apb(1, `TAC_OFS_ACTIONS, 0);
		brake_power <= 16'd2000;
		wbr(1, 1);
		apb(1, `TAC_OFS_RATED_POWER, 0);
		wt(20);
		apb(0, `TAC_OFS_ACCUM, 0);
		chk(rd, 0);
		brake_power <= 16'd0;
		apb(1, `TAC_OFS_ACTIONS, 1);
		soft_trip <= 1;
		wt(3);
		chk(stop_request, 1);
		regen_mode <= 1;
		wt(3);
		chk(stop_request, 0);
		soft_trip <= 0;
		regen_mode <= 0;
		apb(1, `TAC_OFS_ACTIONS, 4);
		phase_loss <= 1;
		wt(5);
		chk(phase_trip, 0);
		motor_stopped <= 1;
		wt(5);
		chk(phase_trip, 1);
		motor_stopped <= 0;
		regen_mode <= 1;
		wt(5);
		chk(phase_trip, 1);
		test_done();
	end
endmodule
